// *** bim_pkg.sv ***
// Shared constants, widths and state types for the bus master link
package bim_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int A_W   = 18;
  localparam int C_W   = 2;
  localparam int D_W   = 16;
  localparam int CNT_W = 12;

  // ------------------------------------------------------------------
  // Transfer type codes on the C lines
  // ------------------------------------------------------------------
  localparam logic [C_W-1:0] CTRL_DATI  = 2'h0;
  localparam logic [C_W-1:0] CTRL_DATIP = 2'h1;

  // ------------------------------------------------------------------
  // Timing, in ns (clock period CLK_PS in ps), and derived cycle counts (rounded up)
  // ------------------------------------------------------------------
  localparam int CLK_PS          = 4000;
  localparam int FE_DESKEW_NS    = 150;
  localparam int DATA_DESKEW_NS  = 75;
  localparam int TAIL_DESKEW_NS  = 75;
  localparam int VEC_DESKEW_NS   = 75;
  localparam int SACK_DELAY_NS   = 75;
  localparam int SSYN_TIMEOUT_NS = 10000;
  localparam int GRANT_TIMEOUT_NS = 5000;

  localparam logic [CNT_W-1:0] FE_CYC =
    CNT_W'((FE_DESKEW_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] DD_CYC =
    CNT_W'((DATA_DESKEW_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] TL_CYC =
    CNT_W'((TAIL_DESKEW_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] VEC_CYC =
    CNT_W'((VEC_DESKEW_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] SACK_CYC =
    CNT_W'((SACK_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] SSYN_TO_CYC =
    CNT_W'((SSYN_TIMEOUT_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] GRANT_TO_CYC =
    CNT_W'((GRANT_TIMEOUT_NS * 1000 + CLK_PS - 1) / CLK_PS);

  // ------------------------------------------------------------------
  // Counter reset and increment values
  // ------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    M_IDLE      = 4'h0,
    M_WAIT_BUS  = 4'h1,
    M_NEXT      = 4'h2,
    M_INT_VEC   = 4'h3,
    M_INT_WAIT  = 4'h4,
    M_INT_DROP  = 4'h5,
    M_RD_SETUP  = 4'h6,
    M_RD_WAIT   = 4'h7,
    M_RD_DESKEW = 4'h8,
    M_RD_TAIL   = 4'h9,
    M_GAP       = 4'ha,
    M_RELEASE   = 4'hb
  } bim_mst_t;

  typedef enum logic [1:0] {
    A_IDLE  = 2'h0,
    A_GRANT = 2'h1,
    A_WAIT  = 2'h2
  } bim_arb_t;

  typedef enum logic [2:0] {
    R_IDLE     = 3'h0,
    R_VEC_SKEW = 3'h1,
    R_VEC_ACK  = 3'h2,
    R_SL_DATA  = 3'h3,
    R_SL_ACK   = 3'h4,
    R_SL_DROP  = 3'h5
  } bim_rsp_t;

endpackage : bim_pkg

// *** bim_if.sv ***
// Shared bus between the bus master and its partners
`timescale 1ns/1ps
interface bim_if;
  import bim_pkg::*;

  logic           br;
  logic           bg;
  logic           m_bbsy;
  logic           bbsy;
  logic           m_sack_o;
  logic           m_sack_oe;
  logic           p_sack_o;
  logic           p_sack_oe;
  logic           sack;
  logic           intr;
  logic           msyn;
  logic           ssyn;
  logic [A_W-1:0] m_a;
  logic [C_W-1:0] m_c;
  logic           m_ac_oe;
  logic [A_W-1:0] a;
  logic [C_W-1:0] c;
  logic [D_W-1:0] m_d_o;
  logic           m_d_oe;
  logic [D_W-1:0] p_d_o;
  logic           p_d_oe;
  logic [D_W-1:0] d;

  // ------------------------------------------------------------------
  // Wired-OR line resolution
  // ------------------------------------------------------------------
  assign bbsy = m_bbsy;
  assign sack = (m_sack_oe & m_sack_o) | (p_sack_oe & p_sack_o);
  assign a    = {A_W{m_ac_oe}} & m_a;
  assign c    = {C_W{m_ac_oe}} & m_c;
  assign d    = ({D_W{m_d_oe}} & m_d_o) | ({D_W{p_d_oe}} & p_d_o);

  modport master (
    input  bg, bbsy, ssyn, d,
    output br, m_bbsy, m_sack_o, m_sack_oe, intr, msyn,
    output m_a, m_c, m_ac_oe, m_d_o, m_d_oe
  );

  modport partner (
    input  br, sack, bbsy, intr, msyn, a, c, d,
    output bg, ssyn, p_sack_o, p_sack_oe, p_d_o, p_d_oe
  );

endinterface : bim_if

// *** bim_master.sv ***
// Bus master: interrupt vector hand-off and data-in read cycles
//
// Summary of operation
// RULE1 - Arbitrator drops unanswered grant after timeout
// RULE2 - Optional terminator echoes grant as SACK
// RULE3 - Arbitrator drops grant on seeing SACK
// RULE4 - Take BBSY only once BBSY seen negated
// RULE5 - Interrupt only under priority grant; vector on D
// RULE6 - INTR after SSYN low; SACK drop afterwards
// RULE7 - Never drop SACK before grant negation
// RULE8 - Processor deskews 75 ns, strobes, asserts SSYN
// RULE9 - On SSYN: vector off, INTR off, BBSY
// RULE10 - Processor negates SSYN after INTR negation
// RULE11 - Arbitrator waits 75 ns, blocks priority grants
// RULE12 - Processor re-enables priority grants later
// RULE13 - At most one interrupt per grant
// RULE14 - Grant holder may do data transfers instead
// RULE15 - Read drives address and type on A, C
// RULE16 - MSYN after 150 ns deskew, SSYN low
// RULE17 - Slave drives data before asserting SSYN
// RULE18 - Deskew, capture data, then negate MSYN
// RULE19 - Slave removes data, then negates SSYN
// RULE20 - Tail deskew, release A/C, BBSY unless held
// RULE21 - Capture data 75 ns after SSYN
// RULE22 - Hold A/C 75 ns after MSYN negation
// RULE23 - SSYN timeout ends read with error
// RULE24 - Delays counted in local clock, rounded up
`timescale 1ns/1ps
module bim_master
  import bim_pkg::*;
(
  input  wire logic           CLK_SYS,
  input  wire logic           RESET,
  input  wire logic           CE,
  bim_if.master               BUS,
  input  wire logic           INT_REQ,
  input  wire logic [D_W-1:0] VECTOR,
  input  wire logic           RD_REQ,
  input  wire logic [A_W-1:0] ADDR,
  input  wire logic [C_W-1:0] CTRL,
  input  wire logic           HOLD,
  output logic                BUSY,
  output logic                INT_DONE,
  output logic                RD_DONE,
  output logic                RD_ERR,
  output logic [D_W-1:0]      RD_DATA
);

  // ------------------------------------------------------------------
  // Bus input synchronisers
  // ------------------------------------------------------------------
  logic [2:0]     s1_reg;
  logic [2:0]     s2_reg;
  logic [D_W-1:0] d1_reg;
  logic [D_W-1:0] d2_reg;
  logic           bg_s;
  logic           bbsy_s;
  logic           ssyn_s;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      d1_reg <= 16'h0000;
      d2_reg <= 16'h0000;
    end else if (CE) begin
      s1_reg <= {BUS.bg, BUS.bbsy, BUS.ssyn};
      s2_reg <= s1_reg;
      d1_reg <= BUS.d;
      d2_reg <= d1_reg;
    end
  end

  assign bg_s   = s2_reg[2];
  assign bbsy_s = s2_reg[1];
  assign ssyn_s = s2_reg[0];

  // ------------------------------------------------------------------
  // Master sequencer
  // ------------------------------------------------------------------
  bim_mst_t       st_reg,       st_next;
  logic [CNT_W-1:0] cnt_reg,    cnt_next;
  logic           br_reg,       br_next;
  logic           sack_reg,     sack_next;
  logic           bbsy_reg,     bbsy_next;
  logic           intr_reg,     intr_next;
  logic           msyn_reg,     msyn_next;
  logic           ac_oe_reg,    ac_oe_next;
  logic [A_W-1:0] a_reg,        a_next;
  logic [C_W-1:0] c_reg,        c_next;
  logic           d_oe_reg,     d_oe_next;
  logic [D_W-1:0] d_reg,        d_next;
  logic           int_sent_reg, int_sent_next;
  logic           to_reg,       to_next;
  logic           busy_reg,     busy_next;
  logic           int_done_reg, int_done_next;
  logic           rd_done_reg,  rd_done_next;
  logic           rd_err_reg,   rd_err_next;
  logic [D_W-1:0] rd_data_reg,  rd_data_next;
  logic           sack_hold;

  always_comb begin
    st_next       = st_reg;
    cnt_next      = (cnt_reg == SSYN_TO_CYC) ? cnt_reg : cnt_reg + CNT_ONE;
    br_next       = br_reg;
    sack_next     = sack_reg;
    bbsy_next     = bbsy_reg;
    intr_next     = intr_reg;
    msyn_next     = msyn_reg;
    ac_oe_next    = ac_oe_reg;
    a_next        = a_reg;
    c_next        = c_reg;
    d_oe_next     = d_oe_reg;
    d_next        = d_reg;
    int_sent_next = int_sent_reg;
    to_next       = to_reg;
    int_done_next = 1'b0;
    rd_done_next  = 1'b0;
    rd_err_next   = rd_err_reg;
    rd_data_next  = rd_data_reg;
    case (st_reg)
      M_IDLE: begin
        br_next = INT_REQ | RD_REQ;
        if ((INT_REQ || RD_REQ) && br_reg && bg_s) begin
          sack_next = 1'b1;
          st_next   = M_WAIT_BUS;
        end
      end
      M_WAIT_BUS: begin
        br_next = 1'b0;
        if (!bbsy_s) begin
          bbsy_next     = 1'b1;                          // [RULE4]
          int_sent_next = 1'b0;
          st_next       = M_NEXT;
        end
      end
      M_NEXT: begin
        if (INT_REQ && !int_sent_reg) begin              // [RULE13]
          d_next    = VECTOR;                            // [RULE5]
          d_oe_next = 1'b1;
          st_next   = M_INT_VEC;
        end else if (RD_REQ) begin                       // [RULE14]
          a_next     = ADDR;                             // [RULE15]
          c_next     = CTRL;
          ac_oe_next = 1'b1;
          to_next    = 1'b0;
          cnt_next   = CNT_RST;
          st_next    = M_RD_SETUP;
        end else if (!HOLD || INT_REQ) begin
          st_next = M_RELEASE;
        end
      end
      M_INT_VEC: begin
        if (!ssyn_s) begin
          intr_next = 1'b1;                              // [RULE6]
          st_next   = M_INT_WAIT;
        end
      end
      M_INT_WAIT: begin
        if (ssyn_s) begin
          d_oe_next = 1'b0;                              // [RULE9]
          st_next   = M_INT_DROP;
        end
      end
      M_INT_DROP: begin
        intr_next     = 1'b0;                            // [RULE9]
        int_sent_next = 1'b1;
        int_done_next = 1'b1;
        st_next       = M_GAP;
      end
      M_RD_SETUP: begin
        if (cnt_reg >= FE_CYC - CNT_ONE && !ssyn_s) begin // [RULE16] [RULE24]
          msyn_next = 1'b1;
          cnt_next  = CNT_RST;
          st_next   = M_RD_WAIT;
        end
      end
      M_RD_WAIT: begin
        if (ssyn_s) begin
          cnt_next = CNT_RST;
          st_next  = M_RD_DESKEW;
        end else if (cnt_reg >= SSYN_TO_CYC - CNT_ONE) begin
          msyn_next = 1'b0;                              // [RULE23]
          to_next   = 1'b1;
          cnt_next  = CNT_RST;
          st_next   = M_RD_TAIL;
        end
      end
      M_RD_DESKEW: begin
        if (cnt_reg >= DD_CYC - CNT_ONE) begin           // [RULE21]
          rd_data_next = d2_reg;                         // [RULE18]
          msyn_next    = 1'b0;
          cnt_next     = CNT_RST;
          st_next      = M_RD_TAIL;
        end
      end
      M_RD_TAIL: begin
        if (cnt_reg >= TL_CYC - CNT_ONE) begin           // [RULE22]
          ac_oe_next   = 1'b0;                           // [RULE20]
          rd_done_next = 1'b1;
          rd_err_next  = to_reg;
          st_next      = M_GAP;
        end
      end
      M_GAP: begin
        st_next = M_NEXT;
      end
      M_RELEASE: begin
        if (!sack_reg) begin
          bbsy_next = 1'b0;                              // [RULE20]
          st_next   = M_IDLE;
        end
      end
      default: begin
        st_next = M_IDLE;
      end
    endcase
    // SACK stays up until the vector phase has INTR on the bus
    sack_hold = (st_reg == M_INT_VEC) ||
                (st_reg == M_NEXT && INT_REQ && !int_sent_reg);
    if (sack_reg && bbsy_reg && !bg_s && !sack_hold) begin
      sack_next = 1'b0;                                  // [RULE6] [RULE7]
    end
    busy_next = (st_next != M_IDLE);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st_reg       <= M_IDLE;
      cnt_reg      <= CNT_RST;
      br_reg       <= 1'b0;
      sack_reg     <= 1'b0;
      bbsy_reg     <= 1'b0;
      intr_reg     <= 1'b0;
      msyn_reg     <= 1'b0;
      ac_oe_reg    <= 1'b0;
      a_reg        <= 18'h00000;
      c_reg        <= 2'h0;
      d_oe_reg     <= 1'b0;
      d_reg        <= 16'h0000;
      int_sent_reg <= 1'b0;
      to_reg       <= 1'b0;
      busy_reg     <= 1'b0;
      int_done_reg <= 1'b0;
      rd_done_reg  <= 1'b0;
      rd_err_reg   <= 1'b0;
      rd_data_reg  <= 16'h0000;
    end else if (CE) begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      br_reg       <= br_next;
      sack_reg     <= sack_next;
      bbsy_reg     <= bbsy_next;
      intr_reg     <= intr_next;
      msyn_reg     <= msyn_next;
      ac_oe_reg    <= ac_oe_next;
      a_reg        <= a_next;
      c_reg        <= c_next;
      d_oe_reg     <= d_oe_next;
      d_reg        <= d_next;
      int_sent_reg <= int_sent_next;
      to_reg       <= to_next;
      busy_reg     <= busy_next;
      int_done_reg <= int_done_next;
      rd_done_reg  <= rd_done_next;
      rd_err_reg   <= rd_err_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign BUS.br        = br_reg;
  assign BUS.m_bbsy    = bbsy_reg;
  assign BUS.m_sack_o  = sack_reg;
  assign BUS.m_sack_oe = sack_reg;
  assign BUS.intr      = intr_reg;
  assign BUS.msyn      = msyn_reg;
  assign BUS.m_a       = a_reg;
  assign BUS.m_c       = c_reg;
  assign BUS.m_ac_oe   = ac_oe_reg;
  assign BUS.m_d_o     = d_reg;
  assign BUS.m_d_oe    = d_oe_reg;
  assign BUSY          = busy_reg;
  assign INT_DONE      = int_done_reg;
  assign RD_DONE       = rd_done_reg;
  assign RD_ERR        = rd_err_reg;
  assign RD_DATA       = rd_data_reg;

endmodule : bim_master

// *** bim_partner.sv ***
// Arbitrator, terminator, interrupt fielding processor and read slave
`timescale 1ns/1ps
module bim_partner
  import bim_pkg::*;
(
  input  wire logic           CLK_SYS,
  input  wire logic           RESET,
  input  wire logic           CE,
  bim_if.partner              BUS,
  input  wire logic           GRANT_EN,
  input  wire logic           IFP_RESUME,
  input  wire logic           TERM_EN,
  input  wire logic           SLV_SEL,
  input  wire logic [D_W-1:0] SLV_DATA,
  output logic                VEC_VALID,
  output logic [D_W-1:0]      VEC_OUT,
  output logic [A_W-1:0]      SLV_ADDR,
  output logic                GRANT_TIMEOUT,
  output logic                BG_BLOCKED
);

  // ------------------------------------------------------------------
  // Bus input synchronisers
  // ------------------------------------------------------------------
  logic [3:0]     s1_reg;
  logic [3:0]     s2_reg;
  logic [A_W+C_W+D_W-1:0] w1_reg;
  logic [A_W+C_W+D_W-1:0] w2_reg;
  logic           br_s;
  logic           sack_s;
  logic           intr_s;
  logic           msyn_s;
  logic [A_W-1:0] a_s;
  logic [C_W-1:0] c_s;
  logic [D_W-1:0] d_s;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      w1_reg <= '0;
      w2_reg <= '0;
    end else if (CE) begin
      s1_reg <= {BUS.br, BUS.sack, BUS.intr, BUS.msyn};
      s2_reg <= s1_reg;
      w1_reg <= {BUS.a, BUS.c, BUS.d};
      w2_reg <= w1_reg;
    end
  end

  assign {br_s, sack_s, intr_s, msyn_s} = s2_reg;
  assign {a_s, c_s, d_s}                = w2_reg;

  // ------------------------------------------------------------------
  // Arbitrator and terminator
  // ------------------------------------------------------------------
  bim_arb_t         ast_reg,  ast_next;
  logic [CNT_W-1:0] acnt_reg, acnt_next;
  logic [CNT_W-1:0] slow_reg, slow_next;
  logic             bg_reg,   bg_next;
  logic             blk_reg,  blk_next;
  logic             intr_d_reg;
  logic             gto_reg,  gto_next;
  logic             term_reg, term_next;

  always_comb begin
    ast_next  = ast_reg;
    acnt_next = acnt_reg + CNT_ONE;
    bg_next   = bg_reg;
    gto_next  = 1'b0;
    slow_next = sack_s ? CNT_RST :
                (slow_reg < SACK_CYC) ? slow_reg + CNT_ONE : slow_reg;
    blk_next  = blk_reg;
    if (IFP_RESUME) begin
      blk_next = 1'b0;                                   // [RULE12]
    end
    if (intr_s && !intr_d_reg) begin
      blk_next = 1'b1;                                   // [RULE11]
    end
    term_next = TERM_EN & bg_reg;                        // [RULE2]
    case (ast_reg)
      A_IDLE: begin
        if (br_s && GRANT_EN && !blk_reg && !sack_s &&
            slow_reg >= SACK_CYC) begin                  // [RULE11] [RULE24]
          bg_next   = 1'b1;
          acnt_next = CNT_RST;
          ast_next  = A_GRANT;
        end
      end
      A_GRANT: begin
        if (sack_s) begin
          bg_next  = 1'b0;                               // [RULE3]
          ast_next = A_WAIT;
        end else if (acnt_reg >= GRANT_TO_CYC - CNT_ONE) begin
          bg_next  = 1'b0;                               // [RULE1]
          gto_next = 1'b1;
          ast_next = A_IDLE;
        end
      end
      A_WAIT: begin
        if (!sack_s) begin
          ast_next = A_IDLE;
        end
      end
      default: begin
        ast_next = A_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ast_reg    <= A_IDLE;
      acnt_reg   <= CNT_RST;
      slow_reg   <= CNT_RST;
      bg_reg     <= 1'b0;
      blk_reg    <= 1'b0;
      intr_d_reg <= 1'b0;
      gto_reg    <= 1'b0;
      term_reg   <= 1'b0;
    end else if (CE) begin
      ast_reg    <= ast_next;
      acnt_reg   <= acnt_next;
      slow_reg   <= slow_next;
      bg_reg     <= bg_next;
      blk_reg    <= blk_next;
      intr_d_reg <= intr_s;
      gto_reg    <= gto_next;
      term_reg   <= term_next;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt fielding processor and read slave
  // ------------------------------------------------------------------
  bim_rsp_t         rst_reg,  rst_next;
  logic [CNT_W-1:0] rcnt_reg, rcnt_next;
  logic             ssyn_reg, ssyn_next;
  logic             doe_reg,  doe_next;
  logic [D_W-1:0]   dout_reg, dout_next;
  logic [D_W-1:0]   vec_reg,  vec_next;
  logic             vv_reg,   vv_next;
  logic [A_W-1:0]   sadr_reg, sadr_next;

  always_comb begin
    rst_next  = rst_reg;
    rcnt_next = rcnt_reg + CNT_ONE;
    ssyn_next = ssyn_reg;
    doe_next  = doe_reg;
    dout_next = dout_reg;
    vec_next  = vec_reg;
    vv_next   = 1'b0;
    sadr_next = sadr_reg;
    case (rst_reg)
      R_IDLE: begin
        if (intr_s) begin
          rcnt_next = CNT_RST;
          rst_next  = R_VEC_SKEW;
        end else if (msyn_s && SLV_SEL &&
                     (c_s == CTRL_DATI || c_s == CTRL_DATIP)) begin
          dout_next = SLV_DATA;
          doe_next  = 1'b1;                              // [RULE17]
          sadr_next = a_s;
          rst_next  = R_SL_DATA;
        end
      end
      R_VEC_SKEW: begin
        if (rcnt_reg >= VEC_CYC - CNT_ONE) begin         // [RULE8]
          vec_next  = d_s;
          vv_next   = 1'b1;
          ssyn_next = 1'b1;
          rst_next  = R_VEC_ACK;
        end
      end
      R_VEC_ACK: begin
        if (!intr_s) begin
          ssyn_next = 1'b0;                              // [RULE10]
          rst_next  = R_IDLE;
        end
      end
      R_SL_DATA: begin
        ssyn_next = 1'b1;                                // [RULE17]
        rst_next  = R_SL_ACK;
      end
      R_SL_ACK: begin
        if (!msyn_s) begin
          doe_next = 1'b0;                               // [RULE19]
          rst_next = R_SL_DROP;
        end
      end
      R_SL_DROP: begin
        ssyn_next = 1'b0;                                // [RULE19]
        rst_next  = R_IDLE;
      end
      default: begin
        rst_next = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rst_reg  <= R_IDLE;
      rcnt_reg <= CNT_RST;
      ssyn_reg <= 1'b0;
      doe_reg  <= 1'b0;
      dout_reg <= 16'h0000;
      vec_reg  <= 16'h0000;
      vv_reg   <= 1'b0;
      sadr_reg <= 18'h00000;
    end else if (CE) begin
      rst_reg  <= rst_next;
      rcnt_reg <= rcnt_next;
      ssyn_reg <= ssyn_next;
      doe_reg  <= doe_next;
      dout_reg <= dout_next;
      vec_reg  <= vec_next;
      vv_reg   <= vv_next;
      sadr_reg <= sadr_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign BUS.bg        = bg_reg;
  assign BUS.ssyn      = ssyn_reg;
  assign BUS.p_sack_o  = term_reg;
  assign BUS.p_sack_oe = term_reg;
  assign BUS.p_d_o     = dout_reg;
  assign BUS.p_d_oe    = doe_reg;
  assign VEC_VALID     = vv_reg;
  assign VEC_OUT       = vec_reg;
  assign SLV_ADDR      = sadr_reg;
  assign GRANT_TIMEOUT = gto_reg;
  assign BG_BLOCKED    = blk_reg;

endmodule : bim_partner

// *** bim_properties.sv ***
// Timing assertions on the shared bus between both ends
`timescale 1ns/1ps
module bim_properties (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic bg,
  input wire logic bbsy,
  input wire logic sack,
  input wire logic intr,
  input wire logic msyn,
  input wire logic ssyn,
  input wire logic m_ac_oe,
  input wire logic m_d_oe
);
  // ------------------------------------------------------------------
  // Handshake order and deskew counts
  // ------------------------------------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  grant_drop_a: assert property (
    $rose(sack) |-> ##[1:5] !bg)
    else $error("grant held after acknowledge");
  sack_hold_a: assert property (
    $fell(sack) |-> !bg && !$past(bg))
    else $error("acknowledge dropped under grant");
  vec_start_a: assert property (
    $rose(intr) |-> m_d_oe && bbsy && !ssyn)
    else $error("strobe without vector");
  vec_off_a: assert property (
    $fell(intr) |-> ssyn && !$past(m_d_oe))
    else $error("vector released late");
  ssyn_drop_a: assert property (
    $fell(intr) |-> ##[1:6] !ssyn)
    else $error("reply held after strobe drop");
  ac_valid_a: assert property (
    msyn |-> m_ac_oe && bbsy)
    else $error("sync without address");
  fe_deskew_a: assert property (
    $rose(msyn) |-> !ssyn && $past(m_ac_oe, 38))
    else $error("front deskew short");
  data_skew_a: assert property (
    $fell(msyn) && ssyn |-> $past(ssyn, 19))
    else $error("data deskew short");
  tail_skew_a: assert property (
    $fell(m_ac_oe) |-> !msyn && !$past(msyn, 19))
    else $error("tail deskew short");
  bus_free_a: assert property (
    $fell(bbsy) |-> !sack && !m_ac_oe && !m_d_oe)
    else $error("bus released while driving");
endmodule : bim_properties

// *** tb_bus_interrupt_and_read_master.sv ***
// Self-checking bench joining the bus master to its partners
`timescale 1ns/1ps
module tb_bus_interrupt_and_read_master;
  import bim_pkg::*;
  logic           clk_sys = 1'b0, reset = 1'b1, int_req = 1'b0;
  logic           rd_req = 1'b0, hold = 1'b0, resume = 1'b0;
  logic           term_en = 1'b0, slv_sel = 1'b1;
  logic [D_W-1:0] vector = 16'h0000, slv_data = 16'h0000, seed = 16'h001f;
  logic [A_W-1:0] addr = 18'h00000;
  logic [C_W-1:0] ctrl = 2'h0;
  logic           int_done, rd_done, rd_err, vec_valid, blocked;
  logic           busy, grant_to;
  logic [D_W-1:0] rd_data, vec_out;
  logic [A_W-1:0] slv_addr;
  int             mismatches = 0, checked = 0, cycles = 0, waited = 0;

  always #2 clk_sys = ~clk_sys;

  bim_if i_bim_if ();
  bim_master i_bim_master (.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1),
    .BUS(i_bim_if), .INT_REQ(int_req), .VECTOR(vector), .RD_REQ(rd_req),
    .ADDR(addr), .CTRL(ctrl), .HOLD(hold), .BUSY(busy), .INT_DONE(int_done),
    .RD_DONE(rd_done), .RD_ERR(rd_err), .RD_DATA(rd_data));
  bim_partner i_bim_partner (.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1),
    .BUS(i_bim_if), .GRANT_EN(1'b1), .IFP_RESUME(resume), .TERM_EN(term_en),
    .SLV_SEL(slv_sel), .SLV_DATA(slv_data), .VEC_VALID(vec_valid),
    .VEC_OUT(vec_out), .SLV_ADDR(slv_addr), .GRANT_TIMEOUT(grant_to),
    .BG_BLOCKED(blocked));
  bim_properties i_bim_properties (.CLK_SYS(clk_sys), .RESET(reset),
    .bg(i_bim_if.bg), .bbsy(i_bim_if.bbsy), .sack(i_bim_if.sack),
    .intr(i_bim_if.intr), .msyn(i_bim_if.msyn), .ssyn(i_bim_if.ssyn),
    .m_ac_oe(i_bim_if.m_ac_oe), .m_d_oe(i_bim_if.m_d_oe));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [15:0] exp_data(input logic [15:0] s);
    return ~s;
  endfunction : exp_data

  task automatic check(input logic [A_W-1:0] seen, input logic [A_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic do_read(input logic sel, input logic [C_W-1:0] c);
    @(posedge clk_sys);
    seed = lfsr(seed);
    addr <= {seed[1:0], seed};
    ctrl <= c;
    slv_data <= exp_data(seed);
    slv_sel <= sel;
    term_en <= seed[7];
    hold <= seed[9];
    rd_req <= 1'b1;
    do @(negedge clk_sys); while (rd_done !== 1'b1);
    check(A_W'(rd_err), A_W'(!sel));
    check(A_W'(busy), A_W'(1'b1));
    if (sel) begin
      check(A_W'(rd_data), A_W'(exp_data(seed)));
      check(slv_addr, {seed[1:0], seed});
    end
    @(posedge clk_sys);
    rd_req <= 1'b0;
  endtask : do_read

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    fork
      begin
        for (int i = 0; i < 2; i++) begin
          @(posedge clk_sys);
          seed = lfsr(seed);
          vector <= seed;
          int_req <= 1'b1;
          do @(negedge clk_sys); while (vec_valid !== 1'b1);
          check(A_W'(vec_out), A_W'(seed));
          do @(negedge clk_sys); while (int_done !== 1'b1);
          check(A_W'(blocked), A_W'(1'b1));
          @(posedge clk_sys);
          int_req <= 1'b0;
          resume <= 1'b1;
          @(posedge clk_sys);
          resume <= 1'b0;
          repeat (4) @(negedge clk_sys);
          check(A_W'(blocked), A_W'(1'b0));
        end
        for (int i = 0; i < 8; i++) do_read(1'b1, C_W'(i % 2));
        do_read(1'b0, CTRL_DATI);
        do_read(1'b1, CTRL_DATIP);
        // Grant left unanswered: request pulsed, no terminator
        hold <= 1'b0;
        term_en <= 1'b0;
        repeat (40) @(posedge clk_sys);
        rd_req <= 1'b1;
        @(posedge clk_sys);
        rd_req <= 1'b0;
        do begin
          @(negedge clk_sys);
          waited++;
        end while (grant_to !== 1'b1);
        check(A_W'(waited >= int'(GRANT_TO_CYC)), A_W'(1'b1));
        check(A_W'(busy), A_W'(1'b0));
      end
      begin
        wait (cycles == 20000);
        mismatches++;
      end
    join_any
    disable fork;
    give_verdict();
  end
endmodule : tb_bus_interrupt_and_read_master
